/* tmrb_params.svh */
`ifndef TMRB_PARAMS_SVH
`define TMRB_PARAMS_SVH
// register offsets
`define TMRB_OFS_INT_TRIP_PROG 8'h13
`define TMRB_OFS_REM_TRIP_PROG 8'h14
`define TMRB_OFS_FACTORY_TEST 8'h15
`define TMRB_OFS_INT_TRIP_FIXED 8'h17
`define TMRB_OFS_REM_TRIP_FIXED 8'h18
`define TMRB_OFS_FAN_DRIVE 8'h19
`define TMRB_OFS_REM_TEMP 8'h26
`define TMRB_OFS_INT_TEMP 8'h27
`define TMRB_OFS_REM_UPPER 8'h37
`define TMRB_OFS_REM_LOWER 8'h38
`define TMRB_OFS_INT_UPPER 8'h39
`define TMRB_OFS_INT_LOWER 8'h3a
`define TMRB_OFS_CONFIG 8'h40
// reset and fixed values, degrees c
`define TMRB_RST_INT_TRIP 8'h7f
`define TMRB_RST_REM_TRIP 8'h64
`define TMRB_FIX_INT_TRIP 8'h46
`define TMRB_FIX_REM_TRIP 8'h64
`define TMRB_RST_FAN 8'h00
`define TMRB_RST_INT_UPPER 8'h7f
`define TMRB_RST_LIMIT 8'h00
`define TMRB_RST_CONFIG 8'h21
`define TMRB_RST_ZERO 8'h00
// configuration bit positions
`define TMRB_CFG_START 0
`define TMRB_CFG_INT_EN 1
`define TMRB_CFG_RSVD 2
`define TMRB_CFG_LOCK 3
`define TMRB_CFG_FAN_FLOAT 5
`define TMRB_CFG_SOFT_RST 4
`define TMRB_CFG_INPUT_INV 6
`define TMRB_CFG_SPARE_HI 7
`endif

/* tmrb_pkg.sv */
package tmrb_pkg;
  // one host register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tmrb_req_t;
  // measured temperatures from the conversion engine
  typedef struct packed {
    logic [7:0] remote;
    logic [7:0] internal;
  } tmrb_meas_t;
  // effective trip points toward the fan logic
  typedef struct packed {
    logic [7:0] internal;
    logic [7:0] remote;
    logic fixed_active;
  } tmrb_trip_t;
  // access phases
  typedef enum logic [1:0] {TMRB_IDLE, TMRB_ANSWER} tmrb_state_t;
endpackage

/* tmrb_sync.sv */
`timescale 1ns/1ps
// two-stage synchroniser for a measurement word from the converter
module tmrb_sync #(
  parameter int WIDTH = 8
) (
  // clock and control
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r; // first stage, read only by the second
  logic [WIDTH-1:0] q_r;
  if (WIDTH < 1) begin : g_bad_width
    $error("tmrb_sync width must be positive");
  end
  // two flops, no logic between
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_r <= '0;
      q_r <= '0;
    end else if (clk_en) begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end
  assign q = q_r;
endmodule

/* tmrb_bank.sv */
`timescale 1ns/1ps
`include "tmrb_params.svh"
// Notes on behaviour
// - internal programmable trip 0x13, resets 127
// - remote programmable trip 0x14, resets 100
// - programmable trips writable only while lock clear
// - fixed internal trip 70, inert when locked
// - fixed remote trip 100, inert when locked
// - fan drive level read/write, resets zero
// - temperature readings read-only, writes ignored
// - remote upper and lower limits read/write
// - internal limits read/write, upper resets 127
// - configuration resets to 0x21
// - bit 0 runs, clear means standby
// - start bit active begins monitoring; resets one
// - bit 1 gates interrupt output, resets zero
// - bit 2 reserved, reads zero
// - lock holds until reset asserted
module tmrb_bank #(
  // width of one measured temperature
  parameter int MEAS_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  // host register access
  input wire tmrb_pkg::tmrb_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  // measurements, from the converter domain
  input wire tmrb_pkg::tmrb_meas_t meas_async,
  // control out
  output logic monitor_run,
  output logic int_out_enable,
  output logic fan_float,
  output logic [7:0] fan_speed_drive,
  output tmrb_pkg::tmrb_trip_t trip
);
  // stored registers
  logic [7:0] int_trip_r, int_trip_nxt;
  logic [7:0] rem_trip_r, rem_trip_nxt;
  logic [7:0] fan_r, fan_nxt;
  logic [7:0] rem_up_r, rem_up_nxt;
  logic [7:0] rem_lo_r, rem_lo_nxt;
  logic [7:0] int_up_r, int_up_nxt;
  logic [7:0] int_lo_r, int_lo_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  // read answer and outputs
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r;
  logic run_r, inten_r, float_r;
  tmrb_pkg::tmrb_trip_t trip_r, trip_nxt;
  tmrb_pkg::tmrb_state_t state_r, state_nxt;
  // settled measurements, one word per channel
  logic [MEAS_W-1:0] rem_temp, int_temp;
  localparam int N_CH = 2; // channel 1 remote, channel 0 internal
  logic [N_CH*MEAS_W-1:0] meas_flat;
  assign meas_flat = meas_async;

  // the read path and the package carry byte-wide readings only
  if (MEAS_W != $bits(rdata) || N_CH * MEAS_W != $bits(tmrb_pkg::tmrb_meas_t)) begin : g_bad_width
    $error("tmrb_bank: measurement width does not match the read path");
  end

  // per channel two flops, then a word is taken only once two samples agree:
  // converter bits may flip at slightly different instants, and a bare
  // synchroniser could hand over a mix of old and new bits
  for (genvar g = 0; g < N_CH; g++) begin : g_meas
    logic [MEAS_W-1:0] sync_q; // after the second flop
    logic [MEAS_W-1:0] prev_r; // previous synchronised word
    logic [MEAS_W-1:0] hold_r; // last word seen steady
    wire steady = (sync_q == prev_r); // two samples agree
    tmrb_sync #(.WIDTH(MEAS_W)) u_sync (
      .ref_clk(ref_clk),
      .rst(rst),
      .clk_en(clk_en),
      .d(meas_flat[g*MEAS_W +: MEAS_W]),
      .q(sync_q)
    );
    // settle filter; costs two cycles of latency, buys a coherent word
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        prev_r <= '0;
        hold_r <= '0;
      end else if (clk_en) begin
        prev_r <= sync_q;
        hold_r <= steady ? sync_q : hold_r;
      end
    end
  end
  assign rem_temp = g_meas[1].hold_r;
  assign int_temp = g_meas[0].hold_r;

  // write decode used for every register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // a write and a read in one cycle are both taken; the read sees the old value
  // write strobes; only listed writable offsets produce one
  wire wr = req.wr;
  wire locked = cfg_r[`TMRB_CFG_LOCK];
  wire wr_int_trip = wr && hit(req.addr, `TMRB_OFS_INT_TRIP_PROG) && !locked;
  wire wr_rem_trip = wr && hit(req.addr, `TMRB_OFS_REM_TRIP_PROG) && !locked;
  wire wr_fan = wr && hit(req.addr, `TMRB_OFS_FAN_DRIVE);
  wire wr_rem_up = wr && hit(req.addr, `TMRB_OFS_REM_UPPER);
  wire wr_rem_lo = wr && hit(req.addr, `TMRB_OFS_REM_LOWER);
  wire wr_int_up = wr && hit(req.addr, `TMRB_OFS_INT_UPPER);
  wire wr_int_lo = wr && hit(req.addr, `TMRB_OFS_INT_LOWER);
  wire wr_cfg = wr && hit(req.addr, `TMRB_OFS_CONFIG);
  // factory test slot deliberately has no strobe: a stray write is harmless

  // next values of the plain registers
  assign int_trip_nxt = wr_int_trip ? req.wdata : int_trip_r;
  assign rem_trip_nxt = wr_rem_trip ? req.wdata : rem_trip_r;
  assign fan_nxt = wr_fan ? req.wdata : fan_r;
  assign rem_up_nxt = wr_rem_up ? req.wdata : rem_up_r;
  assign rem_lo_nxt = wr_rem_lo ? req.wdata : rem_lo_r;
  assign int_up_nxt = wr_int_up ? req.wdata : int_up_r;
  assign int_lo_nxt = wr_int_lo ? req.wdata : int_lo_r;

  // configuration next value: reserved forced low, lock is sticky
  logic [7:0] cfg_wr_val;
  always_comb begin
    cfg_wr_val = req.wdata;
    cfg_wr_val[`TMRB_CFG_RSVD] = 1'b0;
    cfg_wr_val[`TMRB_CFG_LOCK] = locked | req.wdata[`TMRB_CFG_LOCK];
    // soft reset and the two top bits are out of scope here, kept at zero
    cfg_wr_val[`TMRB_CFG_SOFT_RST] = 1'b0;
    cfg_wr_val[`TMRB_CFG_INPUT_INV] = 1'b0;
    cfg_wr_val[`TMRB_CFG_SPARE_HI] = 1'b0;
  end
  assign cfg_nxt = wr_cfg ? cfg_wr_val : cfg_r;

  // read mux; unlisted and test offsets read zero
  always_comb begin
    case (req.addr)
      `TMRB_OFS_INT_TRIP_PROG: rdata_nxt = int_trip_r;
      `TMRB_OFS_REM_TRIP_PROG: rdata_nxt = rem_trip_r;
      `TMRB_OFS_INT_TRIP_FIXED: rdata_nxt = `TMRB_FIX_INT_TRIP;
      `TMRB_OFS_REM_TRIP_FIXED: rdata_nxt = `TMRB_FIX_REM_TRIP;
      `TMRB_OFS_FAN_DRIVE: rdata_nxt = fan_r;
      `TMRB_OFS_REM_TEMP: rdata_nxt = rem_temp;
      `TMRB_OFS_INT_TEMP: rdata_nxt = int_temp;
      `TMRB_OFS_REM_UPPER: rdata_nxt = rem_up_r;
      `TMRB_OFS_REM_LOWER: rdata_nxt = rem_lo_r;
      `TMRB_OFS_INT_UPPER: rdata_nxt = int_up_r;
      `TMRB_OFS_INT_LOWER: rdata_nxt = int_lo_r;
      `TMRB_OFS_CONFIG: rdata_nxt = cfg_r;
      default: rdata_nxt = `TMRB_RST_ZERO;
    endcase
  end

  // the answer strobe is built from this phase, so both always agree
  // access phase machine: a read answers one cycle later
  always_comb begin
    case (state_r)
      tmrb_pkg::TMRB_IDLE: state_nxt = req.rd ? tmrb_pkg::TMRB_ANSWER : tmrb_pkg::TMRB_IDLE;
      tmrb_pkg::TMRB_ANSWER: state_nxt = req.rd ? tmrb_pkg::TMRB_ANSWER : tmrb_pkg::TMRB_IDLE;
      default: state_nxt = tmrb_pkg::TMRB_IDLE;
    endcase
  end

  // built from cfg_r, so a new lock reaches trip one cycle after the config byte
  // effective trip points; fixed ones drop out once locked
  always_comb begin
    trip_nxt.internal = int_trip_r;
    trip_nxt.remote = rem_trip_r;
    trip_nxt.fixed_active = !locked;
    if (!locked) begin
      // before lock the fixed point bounds the programmable one
      if (`TMRB_FIX_INT_TRIP < int_trip_r) trip_nxt.internal = `TMRB_FIX_INT_TRIP;
      if (`TMRB_FIX_REM_TRIP < rem_trip_r) trip_nxt.remote = `TMRB_FIX_REM_TRIP;
    end
  end

  // everything freezes while clk_en is low, the reset branch excepted
  // register storage; reset values from the header
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      int_trip_r <= `TMRB_RST_INT_TRIP;
      rem_trip_r <= `TMRB_RST_REM_TRIP;
      fan_r <= `TMRB_RST_FAN;
      rem_up_r <= `TMRB_RST_LIMIT;
      rem_lo_r <= `TMRB_RST_LIMIT;
      int_up_r <= `TMRB_RST_INT_UPPER;
      int_lo_r <= `TMRB_RST_LIMIT;
      cfg_r <= `TMRB_RST_CONFIG;
    end else if (clk_en) begin
      int_trip_r <= int_trip_nxt;
      rem_trip_r <= rem_trip_nxt;
      fan_r <= fan_nxt;
      rem_up_r <= rem_up_nxt;
      rem_lo_r <= rem_lo_nxt;
      int_up_r <= int_up_nxt;
      int_lo_r <= int_lo_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // answer and control outputs, all registered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= tmrb_pkg::TMRB_IDLE;
      rdata_r <= `TMRB_RST_ZERO;
      rvalid_r <= 1'b0;
      run_r <= 1'b1;
      inten_r <= 1'b0;
      float_r <= 1'b1;
      trip_r <= '0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      rdata_r <= req.rd ? rdata_nxt : rdata_r;
      rvalid_r <= (state_nxt == tmrb_pkg::TMRB_ANSWER); // one answer per taken read
      run_r <= cfg_nxt[`TMRB_CFG_START];
      inten_r <= cfg_nxt[`TMRB_CFG_INT_EN];
      float_r <= cfg_nxt[`TMRB_CFG_FAN_FLOAT];
      trip_r <= trip_nxt;
    end
  end

  assign rdata = rdata_r;
  assign rvalid = rvalid_r;
  assign monitor_run = run_r;
  assign int_out_enable = inten_r;
  assign fan_float = float_r;
  assign fan_speed_drive = fan_r;
  assign trip = trip_r;

  // assertions; those that look one edge back skip the first edge after reset,
  // because the reset edge itself moves the registers they compare
  // a reset held for a single edge must not trip them
  a_lock_blocks_trip: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && $past(clk_en) && !$past(rst) && $past(locked) |-> $stable(int_trip_r) && $stable(rem_trip_r))
    else $error("programmable trip changed while locked");
  a_lock_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rst) && $past(locked) |-> locked)
    else $error("lock bit cleared without reset");
  a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (rst)
    cfg_r[`TMRB_CFG_RSVD] == 1'b0)
    else $error("reserved config bit set");
  a_run_follows_start: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en |=> monitor_run == cfg_r[`TMRB_CFG_START])
    else $error("run output disagrees with start bit");
  a_inten_follows: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en |=> int_out_enable == cfg_r[`TMRB_CFG_INT_EN])
    else $error("interrupt enable disagrees with config");
  a_fixed_int_read: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && req.rd && req.addr == `TMRB_OFS_INT_TRIP_FIXED |=> rvalid && rdata == `TMRB_FIX_INT_TRIP)
    else $error("fixed internal trip read wrong");
  a_fixed_rem_read: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && req.rd && req.addr == `TMRB_OFS_REM_TRIP_FIXED |=> rdata == `TMRB_FIX_REM_TRIP)
    else $error("fixed remote trip read wrong");
  a_fixed_gone_locked: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && locked |=> !trip.fixed_active && trip.internal == $past(int_trip_r))
    else $error("fixed trip still acts after lock");
  a_fan_write: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && wr_fan |=> fan_speed_drive == $past(req.wdata))
    else $error("fan drive write lost");
  a_ro_write_none: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && wr && (req.addr == `TMRB_OFS_REM_TEMP || req.addr == `TMRB_OFS_FACTORY_TEST)
    |=> $stable(cfg_r) && $stable(fan_r) && $stable(int_up_r))
    else $error("read-only write changed state");
  // registers hold their reset values at the first edge after reset
  a_reset_values: assert property (@(posedge ref_clk) disable iff (rst)
    $past(rst) |-> int_trip_r == `TMRB_RST_INT_TRIP && rem_trip_r == `TMRB_RST_REM_TRIP
      && fan_r == `TMRB_RST_FAN && int_up_r == `TMRB_RST_INT_UPPER && cfg_r == `TMRB_RST_CONFIG)
    else $error("register not at its reset value");
  // one answer strobe per taken read, none after a write
  a_rvalid_once: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en |=> rvalid == $past(req.rd))
    else $error("read answer strobe wrong");
  // read data stands until the next taken read
  a_rdata_holds: assert property (@(posedge ref_clk) disable iff (rst)
    !(clk_en && req.rd) |=> $stable(rdata))
    else $error("read data moved without a read");
  // fan float output follows its configuration bit
  a_float_follows: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en |=> fan_float == cfg_r[`TMRB_CFG_FAN_FLOAT])
    else $error("fan float disagrees with config");
  // programmable trips take a write while unlocked
  a_int_trip_write: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && wr && req.addr == `TMRB_OFS_INT_TRIP_PROG && !locked |=> int_trip_r == $past(req.wdata))
    else $error("internal trip write lost");
  a_rem_trip_write: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && wr && req.addr == `TMRB_OFS_REM_TRIP_PROG && !locked |=> rem_trip_r == $past(req.wdata))
    else $error("remote trip write lost");
  // limit registers take every write
  a_rem_up_write: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && wr && req.addr == `TMRB_OFS_REM_UPPER |=> rem_up_r == $past(req.wdata))
    else $error("remote upper limit write lost");
  a_rem_lo_write: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && wr && req.addr == `TMRB_OFS_REM_LOWER |=> rem_lo_r == $past(req.wdata))
    else $error("remote lower limit write lost");
  a_int_up_write: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && wr && req.addr == `TMRB_OFS_INT_UPPER |=> int_up_r == $past(req.wdata))
    else $error("internal upper limit write lost");
  a_int_lo_write: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && wr && req.addr == `TMRB_OFS_INT_LOWER |=> int_lo_r == $past(req.wdata))
    else $error("internal lower limit write lost");
  // readings show the settled measurement
  a_rem_temp_read: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && req.rd && req.addr == `TMRB_OFS_REM_TEMP |=> rdata == $past(rem_temp))
    else $error("remote reading read wrong");
  a_int_temp_read: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && req.rd && req.addr == `TMRB_OFS_INT_TEMP |=> rdata == $past(int_temp))
    else $error("internal reading read wrong");
  // fixed points bound the programmable ones until the lock
  a_trip_bounded: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && !locked |=> trip.fixed_active && trip.internal <= `TMRB_FIX_INT_TRIP
      && trip.remote <= `TMRB_FIX_REM_TRIP)
    else $error("fixed trip not in force before lock");
  a_rem_fixed_gone: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && locked |=> trip.remote == $past(rem_trip_r))
    else $error("fixed remote trip still acts after lock");
  // out-of-scope configuration bits stay zero
  a_cfg_spare_zero: assert property (@(posedge ref_clk) disable iff (rst)
    !cfg_r[`TMRB_CFG_SOFT_RST] && !cfg_r[`TMRB_CFG_INPUT_INV] && !cfg_r[`TMRB_CFG_SPARE_HI])
    else $error("out-of-scope config bit set");
  // writes to read-only places leave stored registers alone
  a_ro_write_trips: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && wr && (req.addr == `TMRB_OFS_INT_TEMP || req.addr == `TMRB_OFS_INT_TRIP_FIXED)
    |=> $stable(int_trip_r) && $stable(rem_trip_r) && $stable(rem_lo_r) && $stable(int_lo_r))
    else $error("read-only write changed a register");
  // a written lock bit takes hold at once
  a_lock_from_write: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && wr && req.addr == `TMRB_OFS_CONFIG && req.wdata[`TMRB_CFG_LOCK] |=> locked)
    else $error("written lock bit not taken");
  // main scenarios reached
  c_lock_set: cover property (@(posedge ref_clk) disable iff (rst) !locked ##1 locked);
  c_standby: cover property (@(posedge ref_clk) disable iff (rst) monitor_run ##1 !monitor_run);
  c_read_temp: cover property (@(posedge ref_clk) disable iff (rst) req.rd && req.addr == `TMRB_OFS_INT_TEMP);
  c_refused_trip: cover property (@(posedge ref_clk) disable iff (rst)
    locked && req.wr && req.addr == `TMRB_OFS_INT_TRIP_PROG);
  c_fan_write: cover property (@(posedge ref_clk) disable iff (rst)
    req.wr && req.addr == `TMRB_OFS_FAN_DRIVE);
endmodule

/* tmrb_host_model.sv */
`timescale 1ns/1ps
// management bus host: one single-byte access at a time
module tmrb_host_model (
  // clock
  input wire logic ref_clk,
  // answer from the bank
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  // request toward the bank
  output tmrb_pkg::tmrb_req_t req
);
  initial req = '0;
  // one byte write, held over exactly one edge
  task automatic put(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk);
    #2;
    if (addr != 8'h15) begin // factory slot is never written
      req = {1'b1, 1'b0, addr, data};
      @(posedge ref_clk);
      #2;
      req = '0;
    end
  endtask
  // one byte read; bounded wait for the answer
  task automatic get(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    int i;
    @(posedge ref_clk);
    #2;
    req = {1'b0, 1'b1, addr, 8'h00};
    @(posedge ref_clk);
    #2;
    req = '0;
    ok = 1'b0;
    data = 8'h00;
    for (i = 0; i < 3 && !ok; i++) begin
      if (rvalid === 1'b1) begin
        data = rdata;
        ok = 1'b1;
      end else begin
        @(posedge ref_clk);
        #2;
      end
    end
  endtask
endmodule

/* thermal_monitor_register_bank_tb_top.sv */
`timescale 1ns/1ps
module thermal_monitor_register_bank_tb_top;
  logic ref_clk, rst, clk_en, rvalid, monitor_run, int_out_enable, fan_float, ok;
  tmrb_pkg::tmrb_req_t req;
  tmrb_pkg::tmrb_meas_t meas_async;
  tmrb_pkg::tmrb_trip_t trip;
  logic [7:0] rdata, fan_speed_drive, d, a;
  int n_errors = 0, n_tests = 0;
  int seed = 32'h985c2b82;
  logic [7:0] mdl [0:255]; // expected register contents
  // every listed offset plus two unlisted
  logic [7:0] ofs [15] = '{8'h13, 8'h14, 8'h15, 8'h17, 8'h18, 8'h19, 8'h26, 8'h27, 8'h37, 8'h38,
    8'h39, 8'h3a, 8'h40, 8'h20, 8'h16};
  logic [7:0] cfgs [4] = '{8'h06, 8'h00, 8'hf6, 8'h21};
  tmrb_bank tmrb_bank_i (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en), .req(req), .rdata(rdata),
    .rvalid(rvalid), .meas_async(meas_async), .monitor_run(monitor_run), .int_out_enable(int_out_enable),
    .fan_float(fan_float), .fan_speed_drive(fan_speed_drive), .trip(trip));
  tmrb_host_model tmrb_host_model_i (.ref_clk(ref_clk), .rdata(rdata), .rvalid(rvalid), .req(req));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // model reload after reset; limits other than internal upper clear
  task automatic mreset();
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[8'h13] = 8'h7f;
    mdl[8'h14] = 8'h64;
    mdl[8'h17] = 8'h46;
    mdl[8'h18] = 8'h64;
    mdl[8'h39] = 8'h7f;
    mdl[8'h40] = 8'h21;
    mdl[8'h26] = meas_async.remote;
    mdl[8'h27] = meas_async.internal;
  endtask
  // what a write leaves behind; unknown and read-only places keep old value
  function automatic logic [7:0] wr_eff(input logic [7:0] ad, input logic [7:0] wd, input logic [7:0] old);
    case (ad)
      8'h13, 8'h14: wr_eff = mdl[8'h40][3] ? old : wd;
      8'h19, 8'h37, 8'h38, 8'h39, 8'h3a: wr_eff = wd;
      8'h40: wr_eff = {2'b00, wd[5], 1'b0, wd[3] | old[3], 1'b0, wd[1:0]};
      default: wr_eff = old;
    endcase
  endfunction
  // effective trip points toward the fan logic
  function automatic logic [16:0] trip_exp();
    logic [7:0] ti, tr;
    ti = (mdl[8'h13] < 8'h46) ? mdl[8'h13] : 8'h46;
    tr = (mdl[8'h14] < 8'h64) ? mdl[8'h14] : 8'h64;
    if (mdl[8'h40][3]) trip_exp = {mdl[8'h13], mdl[8'h14], 1'b0};
    else trip_exp = {ti, tr, 1'b1};
  endfunction
  task automatic mwr(input logic [7:0] ad, input logic [7:0] wd);
    tmrb_host_model_i.put(ad, wd);
    mdl[ad] = wr_eff(ad, wd, mdl[ad]);
  endtask
  task automatic rchk(input logic [7:0] ad);
    tmrb_host_model_i.get(ad, d, ok);
    if (!ok) begin
      n_errors++;
      $display("CHECK FAILED rvalid expected 1 seen 0");
      conclude();
    end else begin
      chk($sformatf("reg %h", ad), mdl[ad], d);
    end
  endtask
  task automatic outs();
    repeat (2) @(posedge ref_clk);
    #2;
    chk("monitor_run", mdl[8'h40][0], monitor_run);
    chk("int_out_enable", mdl[8'h40][1], int_out_enable);
    chk("fan_float", mdl[8'h40][5], fan_float);
    chk("fan_speed_drive", mdl[8'h19], fan_speed_drive);
    chk("trip", trip_exp(), trip);
  endtask
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    meas_async = {8'h31, 8'h28};
    repeat (4) @(posedge ref_clk);
    #2;
    rst = 1'b0;
    mreset();
    // reset contents of every place
    foreach (ofs[i]) rchk(ofs[i]);
    outs();
    $display("test reset values done");
    // limits first, then random traffic incl. read-only and unlisted places
    mwr(8'h37, 8'h50);
    mwr(8'h38, 8'h05);
    mwr(8'h39, 8'h46);
    mwr(8'h3a, 8'h0a);
    mwr(8'h13, 8'h00);
    mwr(8'h13, 8'hff);
    repeat (60) begin
      a = ofs[$unsigned($random(seed)) % 15];
      mwr(a, 8'($random(seed)));
      rchk(ofs[$unsigned($random(seed)) % 13]);
    end
    outs();
    meas_async = 16'($random(seed));
    repeat (4) @(posedge ref_clk);
    mdl[8'h26] = meas_async.remote;
    mdl[8'h27] = meas_async.internal;
    rchk(8'h26);
    rchk(8'h27);
    $display("test random traffic done");
    // configuration bits
    foreach (cfgs[i]) begin
      mwr(8'h40, cfgs[i]);
      rchk(8'h40);
      outs();
    end
    $display("test configuration done");
    // lock, then refused trip writes and a held lock
    mwr(8'h40, 8'h09);
    mwr(8'h13, 8'h55);
    mwr(8'h14, 8'h33);
    mwr(8'h40, 8'h01);
    rchk(8'h13);
    rchk(8'h14);
    rchk(8'h40);
    outs();
    // frozen clock enable: a write must not land
    clk_en = 1'b0;
    tmrb_host_model_i.put(8'h19, ~mdl[8'h19]);
    clk_en = 1'b1;
    outs();
    $display("test lock done");
    // reset clears the lock
    rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #2;
    rst = 1'b0;
    mreset();
    mwr(8'h13, 8'h22);
    rchk(8'h13);
    rchk(8'h40);
    $display("test second reset done");
    conclude();
  end
endmodule
